/* core/idj_cfg.svh */
// constants of the isz/dca/jms cycle sequencer: offsets, fields, codes, resets
`ifndef IDJ_CFG_SVH
`define IDJ_CFG_SVH
`define IDJ_WORD_W    12
`define IDJ_OP_ISZ    3'h2
`define IDJ_OP_DCA    3'h3
`define IDJ_OP_JMS    3'h4
`define IDJ_IND_BIT   8
`define IDJ_PAGE_BIT  7
`define IDJ_REG_CTRL  4'h0
`define IDJ_REG_STAT  4'h4
`define IDJ_REG_CNTR  4'h8
`define IDJ_REG_SUM   4'hc
`define IDJ_CTRL_RUN  0
`define IDJ_CTRL_BRK  1
`define IDJ_WORD_RST  12'h000
`define IDJ_OPC_RST   3'h0
`define IDJ_CTRL_RST  2'h0
`endif

/* core/idj_pkg.sv */
// types of the isz/dca/jms cycle sequencer
package idj_pkg;
`include "idj_cfg.svh"

  typedef logic [`IDJ_WORD_W-1:0] idj_word_t;

  typedef enum logic [1:0] {IDJ_SLOT1, IDJ_SLOT2, IDJ_SLOT3, IDJ_SLOT4} idj_slot_t;

  typedef enum logic [2:0] {IDJ_IDLE, IDJ_FETCH, IDJ_DEFER, IDJ_EXEC, IDJ_BREAK} idj_major_t;

  // request to the core array: start a read/restore cycle, then hand over the write word
  typedef struct packed {
    logic      start;
    logic      write;
    idj_word_t addr;
    idj_word_t data;
  } idj_mem_req_t;

  // answer of the core array
  typedef struct packed {
    logic      sense_valid;
    logic      done;
    idj_word_t sense;
  } idj_mem_rsp_t;

  // register gating network levels
  typedef struct packed {
    logic mem_to_bus;
    logic sum_reg_to_bus;
    logic counter_to_bus;
    logic addr_reg_to_bus;
    logic carry_insert;
    logic buffer_reg_strobe;
    logic sum_reg_strobe;
    logic counter_strobe;
  } idj_gate_t;
endpackage

/* core/idj_core.sv */
// time-state sequencer for increment-skip, deposit-clear and subroutine call
//
// How it works
// - increment-skip fetch as others, opcode two
// - increment-skip slot one reads word into latch
// - slot two adds one, loads buffer, carry sets bypass
// - bypass set, no break pending: counter plus one in slot four
// - incremented word written back same address
// - pulse four enters fetch unless break pending or run clear
// - deposit-clear decoded from opcode three
// - direct deposit-clear enters operand state
// - deposit-clear slot two blocks memory readout
// - slot two: sum register into buffer register
// - slot three loads zeros into sum register
// - buffer written; counter to address; fetch
// - subroutine call decoded from opcode four
// - call slot one: no transfer, word lost
// - call slot two: counter into buffer register
// - call slot three: address plus one to counter
// - call writes saved count to target word
// - call ends in fetch without break, bypass, with run set
// - fetch slot one: address plus one to counter
// - fetch slot two: latch to buffer, opcode
// - pulse four forms page-relative address
// - bit three direct, bit four page zero
// - pulse four picks defer or operand state
// - operand end clears opcode holding register, except with break pending or bypass set
`timescale 1ns/10ps
`include "idj_cfg.svh"

module idj_core
  import idj_pkg::*;
(
  input  wire logic         SYS_CLK,
  input  wire logic         RESET,
  input  wire logic [3:0]   REG_ADDR,
  input  wire idj_word_t    REG_WDATA,
  input  wire logic         REG_WR,
  input  wire logic         REG_RD,
  output idj_word_t         REG_RDATA,
  output idj_mem_req_t      MEM_REQ,
  input  wire idj_mem_rsp_t MEM_RSP,
  output idj_gate_t         GATE
);

  idj_slot_t  slot_q;
  idj_major_t major_q;
  idj_word_t  memory_address_reg_q;
  idj_word_t  memory_buffer_reg_q;
  idj_word_t  program_counter_q;
  idj_word_t  sum_register_q;
  idj_word_t  sense_q;
  logic [2:0] opcode_holding_reg_q;
  logic       skip_q;
  logic [1:0] ctrl_q;
  logic       start_q;
  logic       write_q;
  idj_word_t  rdata_q;
  idj_gate_t  gate;
  logic       active;
  logic       phase1_pulse;
  logic       phase2_pulse;
  logic       phase3_pulse;
  logic       phase4_pulse;
  logic       isz_lvl;
  logic       dca_lvl;
  logic       jms_lvl;
  logic       run;
  logic       brk;
  logic       idle;
  logic       exec_end;
  idj_word_t  bus;
  idj_word_t  sum;
  logic       carry_out;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  function automatic logic is_op(input logic [2:0] opc, input logic [2:0] code);
    return opc == code;
  endfunction

  // opcode decode levels that gate each instruction's transfers
  assign isz_lvl = is_op(opcode_holding_reg_q, `IDJ_OP_ISZ);
  assign dca_lvl = is_op(opcode_holding_reg_q, `IDJ_OP_DCA);
  assign jms_lvl = is_op(opcode_holding_reg_q, `IDJ_OP_JMS);
  assign run     = ctrl_q[`IDJ_CTRL_RUN];
  assign brk     = ctrl_q[`IDJ_CTRL_BRK];
  assign idle    = major_q == IDJ_IDLE;
  assign active  = (major_q == IDJ_FETCH) || (major_q == IDJ_DEFER) || (major_q == IDJ_EXEC);

  // time pulses: slot one ends on sense data, slot four on memory done
  assign phase1_pulse = active && slot_q == IDJ_SLOT1 && MEM_RSP.sense_valid;
  assign phase2_pulse = active && slot_q == IDJ_SLOT2;
  assign phase3_pulse = active && slot_q == IDJ_SLOT3;
  assign phase4_pulse = active && slot_q == IDJ_SLOT4 && MEM_RSP.done;
  assign exec_end     = phase4_pulse && major_q == IDJ_EXEC;

  // gating network levels per major state and slot
  always_comb begin
    gate = '0;
    case (slot_q)
      IDJ_SLOT1: begin
        if (major_q == IDJ_FETCH) begin
          gate.addr_reg_to_bus = 1'b1;
          gate.carry_insert    = 1'b1;
          gate.counter_strobe  = phase1_pulse;
        end
      end // operand slot one moves nothing; word just lands in the latch
      IDJ_SLOT2: begin
        if (major_q == IDJ_FETCH || major_q == IDJ_DEFER) begin
          gate.mem_to_bus        = 1'b1;
          gate.buffer_reg_strobe = 1'b1;
        end else if (major_q == IDJ_EXEC) begin
          if (isz_lvl) begin
            gate.mem_to_bus        = 1'b1;
            gate.carry_insert      = 1'b1;
            gate.buffer_reg_strobe = 1'b1;
          end else if (dca_lvl) begin
            gate.sum_reg_to_bus    = 1'b1;
            gate.buffer_reg_strobe = 1'b1;
          end else if (jms_lvl) begin
            gate.counter_to_bus    = !skip_q;
            gate.buffer_reg_strobe = !skip_q;
          end else begin
            gate.mem_to_bus        = 1'b1; // other opcodes restore operand
            gate.buffer_reg_strobe = 1'b1;
          end
        end
      end
      IDJ_SLOT3: begin
        if (major_q == IDJ_EXEC && dca_lvl) begin
          gate.sum_reg_strobe = 1'b1;
        end else if (major_q == IDJ_EXEC && jms_lvl) begin
          gate.addr_reg_to_bus = 1'b1;
          gate.carry_insert    = 1'b1;
          gate.counter_strobe  = 1'b1;
        end
      end
      IDJ_SLOT4: begin
        if (major_q == IDJ_EXEC && skip_q && !brk) begin
          gate.counter_to_bus = 1'b1;
          gate.carry_insert   = 1'b1;
          gate.counter_strobe = phase4_pulse;
        end
      end
      default: gate = '0;
    endcase
  end

  // bus mux and adders with carry insert at the low bit
  always_comb begin
    bus = '0;
    if (gate.mem_to_bus) bus = bus | sense_q;
    if (gate.sum_reg_to_bus) bus = bus | sum_register_q;
    if (gate.counter_to_bus) bus = bus | program_counter_q;
    if (gate.addr_reg_to_bus) bus = bus | memory_address_reg_q;
    {carry_out, sum} = {1'b0, bus} + {{`IDJ_WORD_W{1'b0}}, gate.carry_insert};
  end

  // slot counter: four slots per memory cycle
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      slot_q <= IDJ_SLOT1;
    end else if (!active) begin
      slot_q <= IDJ_SLOT1;
    end else if (phase1_pulse || phase2_pulse || phase3_pulse || phase4_pulse) begin
      case (slot_q)
        IDJ_SLOT1: slot_q <= IDJ_SLOT2;
        IDJ_SLOT2: slot_q <= IDJ_SLOT3;
        IDJ_SLOT3: slot_q <= IDJ_SLOT4;
        default:   slot_q <= IDJ_SLOT1;
      endcase
    end
  end

  // major state: exactly one of fetch, defer, execute, break while running
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      major_q <= IDJ_IDLE;
    end else begin
      case (major_q)
        IDJ_IDLE:  if (run) major_q <= IDJ_FETCH;
        IDJ_BREAK: if (!brk) major_q <= run ? IDJ_FETCH : IDJ_IDLE;
        IDJ_FETCH: begin
          if (phase4_pulse) begin
            major_q <= memory_buffer_reg_q[`IDJ_IND_BIT] ? IDJ_DEFER : IDJ_EXEC;
          end
        end
        IDJ_DEFER: if (phase4_pulse) major_q <= IDJ_EXEC;
        IDJ_EXEC: begin
          if (phase4_pulse) begin
            if (brk) major_q <= IDJ_BREAK;
            else major_q <= run ? IDJ_FETCH : IDJ_IDLE;
          end
        end
        default: major_q <= IDJ_IDLE;
      endcase
    end
  end

  // core read latch
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) sense_q <= `IDJ_WORD_RST;
    else if (phase1_pulse) sense_q <= MEM_RSP.sense;
  end

  // opcode holding register: load in fetch slot two, clear when operand cycle ends without break or bypass
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      opcode_holding_reg_q <= `IDJ_OPC_RST;
    end else if (phase2_pulse && major_q == IDJ_FETCH) begin
      opcode_holding_reg_q <= sense_q[`IDJ_WORD_W-1 -: 3];
    end else if (exec_end && !brk && !skip_q) begin
      opcode_holding_reg_q <= `IDJ_OPC_RST;
    end
  end

  // bypass flag: set by increment carry out, spent on the counter step
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      skip_q <= 1'b0;
    end else if (phase2_pulse && major_q == IDJ_EXEC && isz_lvl && carry_out) begin
      skip_q <= 1'b1;
    end else if (exec_end && !brk) begin
      skip_q <= 1'b0;
    end
  end

  // buffer register
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) memory_buffer_reg_q <= `IDJ_WORD_RST;
    else if (gate.buffer_reg_strobe) memory_buffer_reg_q <= sum;
  end

  // sum register: software preload while idle, else gating network
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) sum_register_q <= `IDJ_WORD_RST;
    else if (REG_WR && idle && REG_ADDR == `IDJ_REG_SUM) sum_register_q <= REG_WDATA;
    else if (gate.sum_reg_strobe) sum_register_q <= sum;
  end

  // program counter
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) program_counter_q <= `IDJ_WORD_RST;
    else if (REG_WR && idle && REG_ADDR == `IDJ_REG_CNTR) program_counter_q <= REG_WDATA;
    else if (gate.counter_strobe) program_counter_q <= sum;
  end

  // address register
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      memory_address_reg_q <= `IDJ_WORD_RST;
    end else if ((idle && run) || (major_q == IDJ_BREAK && !brk)) begin
      memory_address_reg_q <= program_counter_q;
    end else if (phase4_pulse && major_q == IDJ_FETCH) begin
      memory_address_reg_q <= {memory_buffer_reg_q[`IDJ_PAGE_BIT] ?
                               memory_address_reg_q[`IDJ_WORD_W-1:7] : 5'h00,
                               memory_buffer_reg_q[6:0]};
    end else if (phase4_pulse && major_q == IDJ_DEFER) begin
      memory_address_reg_q <= memory_buffer_reg_q;
    end else if (exec_end && !brk) begin
      memory_address_reg_q <= skip_q ? sum : program_counter_q;
    end
  end

  // memory requests: start on entering slot one, write on entering slot four
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      start_q <= 1'b0;
      write_q <= 1'b0;
    end else begin
      start_q <= (idle && run) || (major_q == IDJ_BREAK && !brk && run) ||
                 (phase4_pulse && !(major_q == IDJ_EXEC && (brk || !run)));
      write_q <= phase3_pulse;
    end
  end

  assign MEM_REQ = '{start: start_q, write: write_q,
                     addr: memory_address_reg_q, data: memory_buffer_reg_q};
  assign GATE    = gate;

  // control register
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) ctrl_q <= `IDJ_CTRL_RST;
    else if (REG_WR && REG_ADDR == `IDJ_REG_CTRL) ctrl_q <= REG_WDATA[1:0];
  end

  // register read, answered one cycle after the strobe
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      rdata_q <= `IDJ_WORD_RST;
    end else if (REG_RD) begin
      case (REG_ADDR)
        `IDJ_REG_CTRL: rdata_q <= {10'h000, ctrl_q};
        `IDJ_REG_STAT: rdata_q <= {3'h0, slot_q, opcode_holding_reg_q, skip_q, major_q};
        `IDJ_REG_CNTR: rdata_q <= program_counter_q;
        `IDJ_REG_SUM:  rdata_q <= sum_register_q;
        default:       rdata_q <= `IDJ_WORD_RST;
      endcase
    end else begin
      rdata_q <= `IDJ_WORD_RST;
    end
  end

  assign REG_RDATA = rdata_q;

  // checks
  sequence call_s2_s;
    major_q == IDJ_EXEC && jms_lvl && slot_q == IDJ_SLOT2 && !skip_q;
  endsequence
  sequence call_s3_s;
    slot_q == IDJ_SLOT3;
  endsequence

  fetch_count_a: assert property (
    phase1_pulse && major_q == IDJ_FETCH |=>
      program_counter_q == idj_word_t'($past(memory_address_reg_q) + 1'b1))
    else $error("fetch did not step the counter");
  opcode_load_a: assert property (
    phase2_pulse && major_q == IDJ_FETCH |=>
      opcode_holding_reg_q == $past(sense_q[11:9]) && memory_buffer_reg_q == $past(sense_q))
    else $error("fetch slot two load wrong");
  page_zero_a: assert property (
    phase4_pulse && major_q == IDJ_FETCH && !memory_buffer_reg_q[7] |=>
      memory_address_reg_q == {5'h00, $past(memory_buffer_reg_q[6:0])})
    else $error("page zero address wrong");
  major_pick_a: assert property (
    phase4_pulse && major_q == IDJ_FETCH |=>
      major_q == ($past(memory_buffer_reg_q[8]) ? IDJ_DEFER : IDJ_EXEC))
    else $error("wrong major state after fetch");
  incr_skip_a: assert property (
    phase2_pulse && major_q == IDJ_EXEC && isz_lvl |=>
      memory_buffer_reg_q == idj_word_t'($past(sense_q) + 1'b1) &&
      skip_q == ($past(sense_q) == 12'hfff))
    else $error("increment or bypass wrong");
  deposit_a: assert property (
    phase2_pulse && major_q == IDJ_EXEC && dca_lvl |=>
      memory_buffer_reg_q == $past(sum_register_q) ##1 sum_register_q == 12'h000)
    else $error("deposit or clear wrong");
  call_save_a: assert property (
    call_s2_s ##1 call_s3_s |=> memory_buffer_reg_q == $past(program_counter_q, 2) &&
      program_counter_q == idj_word_t'($past(memory_address_reg_q) + 1'b1))
    else $error("call did not save and step");
  skip_step_a: assert property (
    exec_end && skip_q && !brk |=> program_counter_q == idj_word_t'($past(program_counter_q) + 1'b1))
    else $error("bypass did not step counter");
  end_fetch_a: assert property (
    exec_end && !brk && run |=> major_q == IDJ_FETCH && start_q &&
      memory_address_reg_q == program_counter_q &&
      opcode_holding_reg_q == ($past(skip_q) ? $past(opcode_holding_reg_q) : 3'h0))
    else $error("operand cycle end wrong");
  break_hold_a: assert property (
    exec_end && brk |=> major_q == IDJ_BREAK && $stable(memory_address_reg_q) && !start_q)
    else $error("break not honoured");
  write_back_a: assert property (
    phase3_pulse |=> write_q && MEM_REQ.data == memory_buffer_reg_q && slot_q == IDJ_SLOT4)
    else $error("write-back not issued");
  slot_walk_a: assert property (
    phase2_pulse |=> slot_q == IDJ_SLOT3 ##1 slot_q == IDJ_SLOT4)
    else $error("slot walk wrong");
  dca_block_a: assert property (
    phase2_pulse && major_q == IDJ_EXEC && dca_lvl |-> !gate.mem_to_bus && gate.sum_reg_to_bus)
    else $error("deposit-clear let memory readout onto the bus");
  call_idle_a: assert property (
    major_q == IDJ_EXEC && jms_lvl && slot_q == IDJ_SLOT1 |-> gate == '0)
    else $error("call slot one moved a register");
  page_rel_a: assert property (
    phase4_pulse && major_q == IDJ_FETCH && memory_buffer_reg_q[7] |=>
      memory_address_reg_q[11:7] == $past(memory_address_reg_q[11:7]) &&
      memory_address_reg_q[6:0] == $past(memory_buffer_reg_q[6:0]))
    else $error("current page address wrong");

endmodule // idj_core

/* verification/idj_mem_model.sv */
// behavioural core memory array: read on start, restore word on write, then done
`timescale 1ns/10ps

module idj_mem_model
  import idj_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         slow,
  input  wire idj_mem_req_t req,
  output idj_mem_rsp_t      rsp
);
  idj_word_t  mem [0:4095];
  idj_word_t  addr_q;
  idj_word_t  word_q;
  logic [1:0] st_q;
  logic [2:0] cnt_q;
  logic       valid_q;
  logic       done_q;

  // sense lines show the inverse of the last word outside the valid cycle
  assign rsp = {valid_q, done_q, valid_q ? word_q : ~word_q};

  // one cycle: start, sense after a delay, write-back, done after a delay
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_q  <= 12'h000;
      word_q  <= 12'h000;
      st_q    <= 2'h0;
      cnt_q   <= 3'h0;
      valid_q <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      valid_q <= 1'b0;
      done_q  <= 1'b0;
      case (st_q)
        2'h0: if (req.start) begin
          addr_q <= req.addr;
          cnt_q  <= slow ? 3'h3 : 3'h0;
          st_q   <= 2'h1;
        end
        2'h1: if (cnt_q != 3'h0) cnt_q <= cnt_q - 3'h1;
        else begin
          valid_q <= 1'b1;
          word_q  <= mem[addr_q];
          st_q    <= 2'h2;
        end
        2'h2: if (req.write) begin
          mem[addr_q] <= req.data; // write goes to the address latched at start
          cnt_q       <= slow ? 3'h3 : 3'h0;
          st_q        <= 2'h3;
        end
        default: if (cnt_q != 3'h0) cnt_q <= cnt_q - 3'h1;
        else begin
          done_q <= 1'b1;
          st_q   <= 2'h0;
        end
      endcase
    end
  end
endmodule // idj_mem_model

/* verification/tb.sv */
// self-checking testbench of the isz/dca/jms cycle sequencer with a core memory model
`timescale 1ns/10ps
`include "idj_cfg.svh"

module tb
  import idj_pkg::*;
;
  logic         clk;
  logic         reset;
  logic [3:0]   reg_addr;
  idj_word_t    reg_wdata;
  logic         reg_wr;
  logic         reg_rd;
  idj_word_t    reg_rdata;
  idj_mem_req_t mem_req;
  idj_mem_rsp_t mem_rsp;
  idj_gate_t    gate;
  logic         slow;
  logic         mix_seen;
  int           errors;
  int           cmp_count;

  idj_core u_idj_core (.SYS_CLK(clk), .RESET(reset), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
    .MEM_REQ(mem_req), .MEM_RSP(mem_rsp), .GATE(gate));

  idj_mem_model u_idj_mem_model (.clk(clk), .rst(reset), .slow(slow), .req(mem_req),
    .rsp(mem_rsp));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // memory readout and sum register must never share the bus
  always @(negedge clk) begin
    if (gate.mem_to_bus === 1'b1 && gate.sum_reg_to_bus === 1'b1) mix_seen <= 1'b1;
  end

  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic cmp_word(input idj_word_t exp, input idj_word_t got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input idj_word_t d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output idj_word_t d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask

  // wait for the next memory cycle start and check its address
  task automatic next_start(input idj_word_t exp);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (mem_req.start !== 1'b1 && n < 400);
    if (n >= 400) begin
      errors++;
      close_out();
    end else cmp_word(exp, mem_req.addr);
  endtask

  task automatic go(input idj_word_t entry, input idj_word_t ctl);
    wr(`IDJ_REG_CNTR, entry);
    wr(`IDJ_REG_CTRL, ctl);
  endtask

  // clear run and wait until the sequencer is idle
  task automatic halt();
    idj_word_t s;
    int n;
    wr(`IDJ_REG_CTRL, 12'h000);
    n = 0;
    do begin
      rd(`IDJ_REG_STAT, s);
      n++;
    end while (s[2:0] !== 3'h0 && n < 60);
    if (n >= 60) begin
      errors++;
      close_out();
    end else cmp_word(12'h000, {9'h000, s[6:4]});
  endtask

  task automatic t_reset();
    idj_word_t d;
    cmp_word(12'h000, {4'h0, gate});
    cmp_word(12'h000, mem_req.addr);
    cmp_word(12'h000, {10'h000, mem_req.start, mem_req.write});
    repeat (14) @(negedge clk);
    rd(`IDJ_REG_STAT, d);
    cmp_word(12'h000, d);
    rd(`IDJ_REG_CNTR, d);
    cmp_word(12'h000, d);
    wr(4'h2, 12'h5a5);
    rd(4'h2, d);
    cmp_word(12'h000, d);
    $display("test reset done");
  endtask

  // increment-skip: page zero or current page, with and without skip
  task automatic t_isz(input idj_word_t entry, input idj_word_t ins, input idj_word_t tgt,
                       input idj_word_t val, input idj_word_t nxt);
    u_idj_mem_model.mem[entry] = ins;
    u_idj_mem_model.mem[tgt] = val;
    go(entry, 12'h001);
    next_start(entry);
    next_start(tgt);
    next_start(nxt);
    halt();
    cmp_word(val + 12'h001, u_idj_mem_model.mem[tgt]);
    cmp_word(ins, u_idj_mem_model.mem[entry]);
    $display("test isz done");
  endtask

  task automatic t_dca();
    idj_word_t d;
    wr(`IDJ_REG_SUM, 12'h5a3);
    u_idj_mem_model.mem[12'h014] = 12'h630;
    u_idj_mem_model.mem[12'h030] = 12'habc;
    mix_seen <= 1'b0;
    go(12'h014, 12'h001);
    next_start(12'h014);
    next_start(12'h030);
    next_start(12'h015);
    halt();
    cmp_word(12'h5a3, u_idj_mem_model.mem[12'h030]);
    rd(`IDJ_REG_SUM, d);
    cmp_word(12'h000, d);
    cmp_word(12'h000, {11'h000, mix_seen});
    $display("test dca done");
  endtask

  // subroutine call against a slow memory
  task automatic t_jms();
    idj_word_t d;
    slow <= 1'b1;
    u_idj_mem_model.mem[12'h0b5] = 12'h840;
    u_idj_mem_model.mem[12'h040] = 12'heee;
    go(12'h0b5, 12'h001);
    next_start(12'h0b5);
    next_start(12'h040);
    next_start(12'h041);
    halt();
    cmp_word(12'h0b6, u_idj_mem_model.mem[12'h040]);
    rd(`IDJ_REG_CNTR, d);
    cmp_word(12'h042, d);
    slow <= 1'b0;
    $display("test jms done");
  endtask

  task automatic t_break();
    idj_word_t d;
    int n;
    u_idj_mem_model.mem[12'h016] = 12'h422;
    u_idj_mem_model.mem[12'h022] = 12'h100;
    go(12'h016, 12'h003);
    next_start(12'h016);
    next_start(12'h022);
    n = 0;
    repeat (40) begin
      @(negedge clk);
      if (mem_req.start === 1'b1) n++;
    end
    cmp_word(12'h000, 12'(n));
    rd(`IDJ_REG_STAT, d);
    cmp_word(12'h004, {9'h000, d[2:0]});
    wr(`IDJ_REG_CTRL, 12'h001);
    next_start(12'h017);
    halt();
    cmp_word(12'h101, u_idj_mem_model.mem[12'h022]);
    $display("test break done");
  endtask

  task automatic t_defer();
    u_idj_mem_model.mem[12'h018] = 12'h523;
    u_idj_mem_model.mem[12'h023] = 12'h300;
    u_idj_mem_model.mem[12'h300] = 12'h7ff;
    go(12'h018, 12'h001);
    next_start(12'h018);
    next_start(12'h023);
    next_start(12'h300);
    next_start(12'h019);
    halt();
    cmp_word(12'h800, u_idj_mem_model.mem[12'h300]);
    $display("test defer done");
  endtask

  // main sequence
  initial begin
    errors = 0;
    cmp_count = 0;
    reset = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 12'h000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    slow = 1'b0;
    mix_seen = 1'b0;
    for (int i = 0; i < 4096; i++) u_idj_mem_model.mem[i] = 12'h000;
    fork
      begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
      end
      begin
        repeat (4) @(negedge clk);
        t_reset();
      end
    join
    t_isz(12'h010, 12'h420, 12'h020, 12'h005, 12'h011);
    t_isz(12'h0a0, 12'h485, 12'h085, 12'hfff, 12'h0a2);
    t_dca();
    t_jms();
    t_break();
    t_defer();
    close_out();
  end
endmodule // tb
